/* hdl/bawin_pkg.sv */
// Purpose: constants and types shared by the address window register ends
// Assumes: one clock, synchronous active-low reset, 64-bit register reads
// Notes:   offsets are byte offsets of 64-bit registers
// How it works
// - outbound register window top fixed, read-only
// - outbound register window base fixed, read-only
// - rom window top fixed, read-only
// - rom window base fixed, read-only
// - bits 63:32 read zero, written zero
// - four writable pci window tops
// - four writable pci window bases
// - pci top points at word's last byte
// - pci base word aligned
// - inbound register window top fixed, read-only
// - inbound register window base fixed, read-only
// - writable memory window tops
// - writable memory window bases
// - memory window tops end on quad word's last byte, bases quad-word aligned
// - four pci enables, reset to zero
// - register and rom enables read one
// - five memory windows, each bound pair
package bawin_pkg;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned DATA_W = 64;
   localparam int unsigned NPCI   = 4;
   localparam int unsigned NMEM   = 5;

   localparam logic [8:0] OFF_CTRL      = 9'h018;
   localparam logic [8:0] OFF_OUT_TOP   = 9'h020;
   localparam logic [8:0] OFF_OUT_BASE  = 9'h028;
   localparam logic [8:0] OFF_ROM_TOP   = 9'h030;
   localparam logic [8:0] OFF_ROM_BASE  = 9'h038;
   localparam logic [8:0] OFF_PCI_FIRST = 9'h040;
   localparam logic [8:0] OFF_IN_TOP    = 9'h080;
   localparam logic [8:0] OFF_IN_BASE   = 9'h088;
   localparam logic [8:0] OFF_MEM_FIRST = 9'h090;
   localparam logic [8:0] OFF_CLAIM     = 9'h160;
   localparam logic [8:0] PAIR_STRIDE   = 9'h010;
   localparam logic [8:0] BASE_STEP     = 9'h008;

   localparam logic [31:0] RST_OUT_TOP  = 32'h1effffff;
   localparam logic [31:0] RST_OUT_BASE = 32'h1e001000;
   localparam logic [31:0] RST_ROM_TOP  = 32'h20ffffff;
   localparam logic [31:0] RST_ROM_BASE = 32'h1f000000;
   localparam logic [31:0] RST_IN_TOP   = 32'h1e000fff;
   localparam logic [31:0] RST_IN_BASE  = 32'h1e000000;
   localparam logic [31:0] RST_BOUND    = 32'h00000000;

   // control word fields
   localparam int unsigned CTRL_INTREG_EN = 0;
   localparam int unsigned CTRL_ROM_EN    = 1;
   localparam int unsigned CTRL_PCI_EN0   = 2;
   localparam logic [3:0]  RST_PCI_EN     = 4'h0;

   // claim word fields: out claims in bits 5:0, in claims in bits 13:8
   localparam int unsigned CLAIM_IN_LSB = 8;

   typedef enum logic [1:0] {
      BAWIN_IDLE  = 2'b00,
      BAWIN_WRITE = 2'b01,
      BAWIN_READ  = 2'b10
   } bawin_op_t;
endpackage

/* hdl/bawin_if.sv */
// Purpose: register link between software-side master and window registers
// Assumes: one clock, master drives strobes, slave answers next cycle
// Notes:   no clocking block; bench joins both ends
`timescale 1ns/1ps
`default_nettype none
interface bawin_if (
   input wire logic i_mclk
);
   import bawin_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [DATA_W-1:0] rdata;

   modport dev (
      input  addr,
      input  wdata,
      input  wr,
      input  rd,
      output rdata
   );
   modport host (
      output addr,
      output wdata,
      output wr,
      output rd,
      input  rdata
   );
endinterface
`default_nettype wire

/* hdl/bawin_regs.sv */
// Purpose: address window bound registers and window claim decode
// Assumes: inputs synchronous to i_mclk
// Notes:   read data one cycle after read strobe
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bawin_regs (
   // clock and reset
   input  wire logic                    i_mclk,
   input  wire logic                    i_rstn,
   // register link
   bawin_if.dev                         bus,
   // address decode
   input  wire logic [31:0]             i_out_addr,
   input  wire logic [31:0]             i_in_addr,
   output logic [5:0]                   o_out_claim,
   output logic [5:0]                   o_in_claim
);
   import bawin_pkg::*;

   logic [31:0] pci_top_ff   [NPCI];
   logic [31:0] pci_base_ff  [NPCI];
   logic [31:0] mem_top_ff   [NMEM];
   logic [31:0] mem_base_ff  [NMEM];
   logic [3:0]  pci_en_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic [5:0]  nxt_out_claim;
   logic [5:0]  nxt_in_claim;
   // one-hot bank selects, decoded once for the write and read paths
   logic              ctrl_sel;
   logic [NPCI-1:0]   pci_top_sel;
   logic [NPCI-1:0]   pci_base_sel;
   logic [NMEM-1:0]   mem_top_sel;
   logic [NMEM-1:0]   mem_base_sel;
   logic [DATA_W-1:0] ctrl_word;
   logic [DATA_W-1:0] claim_word;

   function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [63:0] zx(input logic [31:0] v);
      zx = {32'h00000000, v};
   endfunction

   // byte offset of a bank's nth top, or of its base one step above
   function automatic logic [8:0] pair_off(input logic [8:0] first, input int n,
                                           input logic is_base);
      pair_off = first + 9'(n) * PAIR_STRIDE + (is_base ? BASE_STEP : 9'h000);
   endfunction

   // decode once: a compare tree per write and read port would cost twice the area
   always_comb begin
      ctrl_sel     = (bus.addr == OFF_CTRL);
      pci_top_sel  = '0;
      pci_base_sel = '0;
      mem_top_sel  = '0;
      mem_base_sel = '0;
      for (int i = 0; i < NPCI; i++) begin
         pci_top_sel[i]  = (bus.addr == pair_off(OFF_PCI_FIRST, i, 1'b0));
         pci_base_sel[i] = (bus.addr == pair_off(OFF_PCI_FIRST, i, 1'b1));
      end
      for (int i = 0; i < NMEM; i++) begin
         mem_top_sel[i]  = (bus.addr == pair_off(OFF_MEM_FIRST, i, 1'b0));
         mem_base_sel[i] = (bus.addr == pair_off(OFF_MEM_FIRST, i, 1'b1));
      end
   end

   // fixed window enables always read one; only the pci enables are stored
   always_comb begin
      ctrl_word                       = '0;
      ctrl_word[CTRL_INTREG_EN]       = 1'b1;
      ctrl_word[CTRL_ROM_EN]          = 1'b1;
      ctrl_word[CTRL_PCI_EN0 +: NPCI] = pci_en_ff;
   end

   always_comb begin
      claim_word                    = '0;
      claim_word[5:0]               = o_out_claim;
      claim_word[CLAIM_IN_LSB +: 6] = o_in_claim;
   end

   // writes: only bits 31:0 stored; fixed bounds have no write path
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         pci_en_ff <= RST_PCI_EN;
      end else if (bus.wr && ctrl_sel) begin
         pci_en_ff <= bus.wdata[CTRL_PCI_EN0 +: NPCI];
      end
   end

   // bounds reset to zero so simulation never shows unknowns
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         for (int i = 0; i < NPCI; i++) begin
            pci_top_ff[i]  <= RST_BOUND;
            pci_base_ff[i] <= RST_BOUND;
         end
      end else if (bus.wr) begin
         for (int i = 0; i < NPCI; i++) begin
            if (pci_top_sel[i]) begin
               pci_top_ff[i] <= bus.wdata[31:0];
            end
            if (pci_base_sel[i]) begin
               pci_base_ff[i] <= bus.wdata[31:0];
            end
         end
      end
   end

   // inbound memory window bounds, same reset choice as the pci bounds
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         for (int i = 0; i < NMEM; i++) begin
            mem_top_ff[i]  <= RST_BOUND;
            mem_base_ff[i] <= RST_BOUND;
         end
      end else if (bus.wr) begin
         for (int i = 0; i < NMEM; i++) begin
            if (mem_top_sel[i]) begin
               mem_top_ff[i] <= bus.wdata[31:0];
            end
            if (mem_base_sel[i]) begin
               mem_base_ff[i] <= bus.wdata[31:0];
            end
         end
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      nxt_rdata = '0;
      unique case (bus.addr)
         OFF_CTRL:     nxt_rdata = ctrl_word;
         OFF_OUT_TOP:  nxt_rdata = zx(RST_OUT_TOP);
         OFF_OUT_BASE: nxt_rdata = zx(RST_OUT_BASE);
         OFF_ROM_TOP:  nxt_rdata = zx(RST_ROM_TOP);
         OFF_ROM_BASE: nxt_rdata = zx(RST_ROM_BASE);
         OFF_IN_TOP:   nxt_rdata = zx(RST_IN_TOP);
         OFF_IN_BASE:  nxt_rdata = zx(RST_IN_BASE);
         OFF_CLAIM:    nxt_rdata = claim_word;
         default: begin
            for (int i = 0; i < NPCI; i++) begin
               if (pci_top_sel[i]) begin
                  nxt_rdata = zx(pci_top_ff[i]);
               end
               if (pci_base_sel[i]) begin
                  nxt_rdata = zx(pci_base_ff[i]);
               end
            end
            for (int i = 0; i < NMEM; i++) begin
               if (mem_top_sel[i]) begin
                  nxt_rdata = zx(mem_top_ff[i]);
               end
               if (mem_base_sel[i]) begin
                  nxt_rdata = zx(mem_base_ff[i]);
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         rdata_ff <= '0;
      end else if (bus.rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= '0;
      end
   end

   assign bus.rdata = rdata_ff;

   // claim decode, registered so outputs come from flops
   always_comb begin
      nxt_out_claim    = '0;
      nxt_out_claim[0] = in_win(i_out_addr, RST_OUT_BASE, RST_OUT_TOP);
      nxt_out_claim[1] = in_win(i_out_addr, RST_ROM_BASE, RST_ROM_TOP);
      for (int i = 0; i < NPCI; i++) begin
         nxt_out_claim[2+i] = pci_en_ff[i] &&
                              in_win(i_out_addr, pci_base_ff[i], pci_top_ff[i]);
      end
   end

   // inbound memory windows have no enable bit; stored bounds alone decide
   always_comb begin
      nxt_in_claim    = '0;
      nxt_in_claim[0] = in_win(i_in_addr, RST_IN_BASE, RST_IN_TOP);
      for (int i = 0; i < NMEM; i++) begin
         nxt_in_claim[1+i] = in_win(i_in_addr, mem_base_ff[i], mem_top_ff[i]);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_out_claim <= '0;
      end else begin
         o_out_claim <= nxt_out_claim;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_in_claim <= '0;
      end else begin
         o_in_claim <= nxt_in_claim;
      end
   end
endmodule
`default_nettype wire

/* hdl/bawin_host.sv */
// Purpose: software-side master issuing single register reads and writes
// Assumes: user requests one cycle long, one at a time
// Notes:   aligns bounds before writing; high word always zero
`timescale 1ns/1ps
`default_nettype none
module bawin_host (
   // clock and reset
   input  wire logic                    i_mclk,
   input  wire logic                    i_rstn,
   // user side
   input  wire bawin_pkg::bawin_op_t    i_op,
   input  wire logic [8:0]              i_addr,
   input  wire logic [31:0]             i_wdata,
   output logic [31:0]                  o_rdata,
   output logic                         o_rvalid,
   // register link
   bawin_if.host                        bus
);
   import bawin_pkg::*;

   logic [8:0]  addr_ff;
   logic [63:0] wdata_ff;
   logic        wr_ff;
   logic        rd_ff;
   logic        rd_q_ff;
   logic [31:0] nxt_w;

   // pci tops end on a word's last byte, bases on a word; mem on quad words
   always_comb begin
      nxt_w = i_wdata;
      if (i_addr >= OFF_PCI_FIRST && i_addr < OFF_IN_TOP) begin
         nxt_w = i_addr[3] ? {i_wdata[31:2], 2'b00}
                           : {i_wdata[31:2], 2'b11};
      end else if (i_addr >= OFF_MEM_FIRST && i_addr < OFF_CLAIM) begin
         nxt_w = i_addr[3] ? {i_wdata[31:4], 4'h0}
                           : {i_wdata[31:4], 4'hf};
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         addr_ff  <= '0;
         wdata_ff <= '0;
         wr_ff    <= 1'b0;
         rd_ff    <= 1'b0;
      end else begin
         addr_ff  <= i_addr;
         wdata_ff <= {32'h00000000, nxt_w};
         wr_ff    <= (i_op == BAWIN_WRITE);
         rd_ff    <= (i_op == BAWIN_READ);
      end
   end

   // slave answers the cycle after the strobe; take the data only then
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         rd_q_ff  <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata  <= '0;
      end else begin
         rd_q_ff  <= rd_ff;
         o_rvalid <= rd_q_ff;
         if (rd_q_ff) begin
            o_rdata <= bus.rdata[31:0];
         end
      end
   end

   assign bus.addr  = addr_ff;
   assign bus.wdata = wdata_ff;
   assign bus.wr    = wr_ff;
   assign bus.rd    = rd_ff;
endmodule
`default_nettype wire

/* bench/bawin_chk.sv */
// Purpose: link checks for the window register ends
// Assumes: one clock, sync active-low reset
// Notes:   sees only the link signals
`timescale 1ns/1ps
`default_nettype none
module bawin_chk
   import bawin_pkg::*;
(
   // clock and reset
   input wire logic              i_mclk,
   input wire logic              i_rstn,
   // link
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [DATA_W-1:0] rdata
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);
   logic pci_w;
   logic mem_w;
   assign pci_w = wr && addr >= OFF_PCI_FIRST && addr < OFF_IN_TOP;
   assign mem_w = wr && addr >= OFF_MEM_FIRST && addr < 9'h0e0;
   chk_out_top: assert property (rd && addr == OFF_OUT_TOP |=> rdata == {32'h0, RST_OUT_TOP})
      else $error("out top bad");
   chk_rom_top: assert property (rd && addr == OFF_ROM_TOP |=> rdata == {32'h0, RST_ROM_TOP})
      else $error("rom top bad");
   chk_in_base: assert property (rd && addr == OFF_IN_BASE |=> rdata == {32'h0, RST_IN_BASE})
      else $error("in base bad");
   chk_high_read: assert property (rd |=> rdata[63:32] == 32'h0)
      else $error("high word read");
   chk_high_write: assert property (wr |-> wdata[63:32] == 32'h0)
      else $error("high word written");
   chk_pci_top: assert property (pci_w && !addr[3] |-> wdata[1:0] == 2'h3)
      else $error("pci top align");
   chk_pci_base: assert property (pci_w && addr[3] |-> wdata[1:0] == 2'h0)
      else $error("pci base align");
   chk_mem_align: assert property (mem_w |-> wdata[3:0] == (addr[3] ? 4'h0 : 4'hf))
      else $error("mem align");
   chk_ctrl_fixed: assert property (rd && addr == OFF_CTRL |=> rdata[1:0] == 2'h3)
      else $error("fixed enables");
   cover property (rd && addr == OFF_CTRL);
   cover property (pci_w);
   cover property (mem_w);
endmodule
`default_nettype wire

/* bench/bridge_address_windows_test.sv */
// Purpose: bench joining host master and window registers
// Assumes: 50 ns clock, reset held 20 cycles
// Notes:   outputs sampled on falling edges, clear of updates
`timescale 1ns/1ps
`default_nettype none
module bridge_address_windows_test;
   import bawin_pkg::*;
   logic        i_mclk = 1'b0;
   logic        i_rstn = 1'b0;
   bawin_op_t   op     = BAWIN_IDLE;
   logic [8:0]  addr   = 9'h0;
   logic [31:0] wdata  = 32'h0;
   logic [31:0] oa     = 32'h0;
   logic [31:0] ia     = 32'h0;
   logic [31:0] rdata;
   logic        rvalid;
   logic [5:0]  oc;
   logic [5:0]  ic;
   logic [31:0] got;
   int          mismatches = 0;
   int          compares   = 0;
   int          cycles     = 0;
   logic [8:0]  offs [6] = '{OFF_OUT_TOP, OFF_OUT_BASE, OFF_ROM_TOP, OFF_ROM_BASE,
                             OFF_IN_TOP, OFF_IN_BASE};
   logic [31:0] vals [6] = '{RST_OUT_TOP, RST_OUT_BASE, RST_ROM_TOP, RST_ROM_BASE,
                             RST_IN_TOP, RST_IN_BASE};
   always #25 i_mclk = ~i_mclk;
   bawin_if bus (.i_mclk(i_mclk));
   bawin_regs i_bawin_regs (.i_mclk(i_mclk), .i_rstn(i_rstn), .bus(bus), .i_out_addr(oa),
      .i_in_addr(ia), .o_out_claim(oc), .o_in_claim(ic));
   bawin_host i_bawin_host (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_op(op), .i_addr(addr),
      .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid), .bus(bus));
   bawin_chk i_bawin_chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .addr(bus.addr),
      .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
      op <= BAWIN_WRITE;
      addr <= a;
      wdata <= d;
      @(posedge i_mclk);
      op <= BAWIN_IDLE;
      repeat (2) @(posedge i_mclk);
   endtask
   // host answers two cycles after the op edge; a missing answer keeps the marker
   task automatic rd_reg(input logic [8:0] a);
      op <= BAWIN_READ;
      addr <= a;
      @(posedge i_mclk);
      op <= BAWIN_IDLE;
      got = 32'hdeadbeef;
      for (int n = 0; n < 4; n++) begin
         @(negedge i_mclk);
         if (rvalid === 1'b1) got = rdata;
      end
      @(posedge i_mclk);
   endtask
   task automatic claim(input logic [31:0] o, input logic [31:0] i, input logic [5:0] eo,
                        input logic [5:0] ei);
      oa <= o;
      ia <= i;
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      check("out claim", {26'h0, oc}, {26'h0, eo});
      check("in claim", {26'h0, ic}, {26'h0, ei});
      @(posedge i_mclk);
   endtask
   task automatic t_fixed;
      for (int k = 0; k < 6; k++) begin
         rd_reg(offs[k]);
         check("fixed bound", got, vals[k]);
         wr_reg(offs[k], ~vals[k]);
         rd_reg(offs[k]);
         check("fixed after write", got, vals[k]);
      end
      rd_reg(OFF_CTRL);
      check("enables at reset", got, 32'h3);
      rd_reg(9'h1f8);
      check("unmapped", got, 32'h0);
   endtask
   // pci windows 0..3 then memory windows 0..4, all at distinct pages
   task automatic t_bounds;
      logic [8:0]  a;
      logic [31:0] m;
      logic [31:0] t;
      for (int w = 0; w < 9; w++) begin
         a = (w < 4) ? OFF_PCI_FIRST + 9'(16 * w) : OFF_MEM_FIRST + 9'(16 * (w - 4));
         m = (w < 4) ? 32'h3 : 32'hf;
         t = 32'h40000000 + 32'(w) * 32'h1000;
         wr_reg(a, t + 32'hff0);
         wr_reg(a + BASE_STEP, t + 32'h1);
         rd_reg(a);
         check("window top", got, (t + 32'hff0) | m);
         rd_reg(a + BASE_STEP);
         check("window base", got, t);
      end
   endtask
   task automatic t_claims;
      claim(32'h1e001000, 32'h1e000000, 6'h01, 6'h01);
      claim(32'h1effffff, 32'h1e000fff, 6'h01, 6'h01);
      claim(32'h1e000fff, 32'h1e001000, 6'h00, 6'h00);
      claim(32'h1f000000, 32'h1dffffff, 6'h02, 6'h00);
      // memory bounds still zero: address zero falls in all five windows
      claim(32'h21000000, 32'h0, 6'h00, 6'h3e);
      claim(32'h20ffffff, 32'h0, 6'h02, 6'h3e);
      t_bounds();
      claim(32'h40000000, 32'h40004000, 6'h00, 6'h02);
      wr_reg(OFF_CTRL, 32'h3c);
      rd_reg(OFF_CTRL);
      check("enables set", got, 32'h3f);
      claim(32'h40000ff3, 32'h40008fff, 6'h04, 6'h20);
      claim(32'h40000ff4, 32'h40003fff, 6'h00, 6'h00);
      claim(32'h40003000, 32'h40005000, 6'h20, 6'h04);
      rd_reg(OFF_CLAIM);
      check("claim word", got, 32'h00000420);
      wr_reg(OFF_CTRL, 32'h38);
      claim(32'h40000000, 32'h40004fff, 6'h00, 6'h02);
   endtask
   task automatic complete_run;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles > 3000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      repeat (20) @(posedge i_mclk);
      i_rstn <= 1'b1;
      @(posedge i_mclk);
      t_fixed();
      t_claims();
      complete_run();
   end
endmodule
`default_nettype wire
